// [hdl/otpfw_core.sv]
// Fuse programming sequencer with wiper code register and validation status.
// Assumes the serial bus front end decodes writes, triggers and reads; fuses are
// modelled by burn strobes and sense inputs; reset stands for power-on.
// Trade-off: a fixed pacing divider keeps every burn period equal, whatever the fuse speed.
// Limitation: the test fuse must read as blown by the end of its own pacing period, data fuses by the end of the compare period.
// Functional notes
// - Unlocked power-on loads midscale code.
// - Eight-bit wiper code, unlimited writes before lock.
// - Two-bit validation status readable by host.
// - Status 00 ready,01 test,10 mismatch,11 done.
// - Trigger enables internal pacing clock.
// - Test fuse fail stops with 01.
// - Eight data fuses, one per tick.
// - Compare fuses to code; mismatch gives 10.
// - Retry allowed after mismatch.
// - Match blows lock, status 11, refuse more.
// - Fuse latches read at power-on.
// - Eight data, one test, one lock fuse.
// - Code selects one of 256 taps.
// - Wiper-to-A falls as code rises.
`default_nettype none

module otpfw_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic codeWrite,
	input wire logic [7:0] codeData,
	input wire logic burnTrigger,
	input wire logic testFuseSense,
	input wire logic [7:0] dataFuseSense,
	input wire logic lockFuseSense,
	output logic testFuseBurn,
	output logic [7:0] dataFuseBurn,
	output logic lockFuseBurn,
	output logic [7:0] wiperCode,
	output logic [255:0] tapSelect,
	output logic [7:0] wiperToACode,
	output logic validation_hi,
	output logic validation_lo,
	output logic busy
);
	otpfw_pkg::otpfw_state_t state_reg;
	logic [7:0] wiper_code_reg;
	logic [1:0] status_reg;
	logic [2:0] bit_reg;
	logic bootDone_reg;
	logic testBurn_reg;
	logic [7:0] dataBurn_reg;
	logic lockBurn_reg;
	logic tick;
	logic running;
	logic locked;
	logic startSeq;
	logic fuseMatch;

	// ==========================================================
	// Pacing clock runs only during a sequence
	assign running = (state_reg != otpfw_pkg::OTPFW_IDLE);
	otpfw_tick u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.run(running),
		.tick(tick)
	);

	// Lock state comes from the fuse or the stored status
	assign locked = lockFuseSense || (status_reg == otpfw_pkg::VAL_LOCKED);
	assign startSeq = burnTrigger && !running && !locked && bootDone_reg;
	assign fuseMatch = (dataFuseSense == wiper_code_reg);

	// ==========================================================
	// Wiper register: midscale or fused latches after power-on, then host writes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wiper_code_reg <= otpfw_pkg::MIDSCALE_CODE;
		else if (!bootDone_reg && lockFuseSense)
			wiper_code_reg <= dataFuseSense;
		else if (codeWrite && !running && !locked)
			wiper_code_reg <= codeData;
	end

	// Latch sampling happens once, on the first edge after release
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bootDone_reg <= 1'b0;
		else
			bootDone_reg <= 1'b1;
	end

	// ==========================================================
	// Sequencer; burn strobes are held for one pacing period each
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= otpfw_pkg::OTPFW_IDLE;
			status_reg <= otpfw_pkg::VAL_READY;
			bit_reg <= 3'h0;
			testBurn_reg <= 1'b0;
			dataBurn_reg <= 8'h00;
			lockBurn_reg <= 1'b0;
		end
		else if (!bootDone_reg)
		begin
			if (lockFuseSense)
				status_reg <= otpfw_pkg::VAL_LOCKED;
		end
		else
		begin
			unique case (state_reg)
				otpfw_pkg::OTPFW_IDLE:
				begin
					if (startSeq)
					begin
						state_reg <= otpfw_pkg::OTPFW_TEST;
						testBurn_reg <= 1'b1;
						bit_reg <= 3'h0;
					end
				end
				otpfw_pkg::OTPFW_TEST:
				begin
					if (tick)
					begin
						testBurn_reg <= 1'b0;
						if (!testFuseSense)
						begin
							state_reg <= otpfw_pkg::OTPFW_IDLE;
							status_reg <= otpfw_pkg::VAL_TEST_FAIL;
						end
						else
						begin
							state_reg <= otpfw_pkg::OTPFW_DATA;
							dataBurn_reg <= {7'h00, wiper_code_reg[0]};
						end
					end
				end
				otpfw_pkg::OTPFW_DATA:
				begin
					if (tick)
					begin
						if (bit_reg == otpfw_pkg::DATA_FUSE_LAST)
						begin
							dataBurn_reg <= 8'h00;
							state_reg <= otpfw_pkg::OTPFW_CMP;
						end
						else
						begin
							bit_reg <= bit_reg + 3'h1;
							dataBurn_reg <= wiper_code_reg & (8'h01 << (bit_reg + 3'h1));
						end
					end
				end
				otpfw_pkg::OTPFW_CMP:
				begin
					if (tick)
					begin
						if (fuseMatch)
						begin
							state_reg <= otpfw_pkg::OTPFW_LOCK;
							lockBurn_reg <= 1'b1;
						end
						else
						begin
							state_reg <= otpfw_pkg::OTPFW_IDLE;
							status_reg <= otpfw_pkg::VAL_MISMATCH;
						end
					end
				end
				otpfw_pkg::OTPFW_LOCK:
				begin
					if (tick)
					begin
						lockBurn_reg <= 1'b0;
						state_reg <= otpfw_pkg::OTPFW_IDLE;
						status_reg <= otpfw_pkg::VAL_LOCKED;
					end
				end
				default:
					state_reg <= otpfw_pkg::OTPFW_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Outputs; tap decode is one-hot, A-side code is the complement
	assign testFuseBurn = testBurn_reg;
	assign dataFuseBurn = dataBurn_reg;
	assign lockFuseBurn = lockBurn_reg;
	assign wiperCode = wiper_code_reg;
	assign tapSelect = 256'(1) << wiper_code_reg;
	assign wiperToACode = ~wiper_code_reg;
	assign validation_hi = status_reg[1];
	assign validation_lo = status_reg[0];
	assign busy = running;

	// ==========================================================
	// Assertions
	property p_midscale;
		@(posedge clk) disable iff (!rst_n)
		($rose(bootDone_reg) && !$past(lockFuseSense)) |-> wiper_code_reg == otpfw_pkg::MIDSCALE_CODE;
	endproperty
	a_midscale: assert property (p_midscale) else $error("not midscale after reset");

	property p_write;
		@(posedge clk) disable iff (!rst_n)
		(codeWrite && !running && !locked && bootDone_reg) |=> wiper_code_reg == $past(codeData);
	endproperty
	a_write: assert property (p_write) else $error("code write lost");

	property p_testfail;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == otpfw_pkg::OTPFW_TEST && tick && !testFuseSense) |=> status_reg == 2'h1 && !running;
	endproperty
	a_testfail: assert property (p_testfail) else $error("test fail not reported");

	property p_mismatch;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == otpfw_pkg::OTPFW_CMP && tick && !fuseMatch) |=> status_reg == 2'h2;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch not reported");

	property p_lock;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == otpfw_pkg::OTPFW_CMP && tick && fuseMatch) |=> lockBurn_reg ##[1:60] status_reg == 2'h3;
	endproperty
	a_lock: assert property (p_lock) else $error("lock not completed");

	property p_refuse;
		@(posedge clk) disable iff (!rst_n)
		(status_reg == 2'h3 && !running) |=> !running;
	endproperty
	a_refuse: assert property (p_refuse) else $error("programming after lock");

	property p_start;
		@(posedge clk) disable iff (!rst_n)
		startSeq |=> running && testBurn_reg;
	endproperty
	a_start: assert property (p_start) else $error("trigger did not start");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(!running && !startSeq && bootDone_reg) |=> $stable(status_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("status changed while idle");

	property p_onehot;
		@(posedge clk) disable iff (!rst_n)
		$countones(dataBurn_reg) <= 1;
	endproperty
	a_onehot: assert property (p_onehot) else $error("several data fuses at once");

	// ==========================================================
	// Strobes, decode, retries and refused requests
	property p_refusewrite;
		@(posedge clk) disable iff (!rst_n)
		(codeWrite && (running || locked) && bootDone_reg) |=> $stable(wiper_code_reg);
	endproperty
	a_refusewrite: assert property (p_refusewrite) else $error("code changed while busy or locked");

	property p_retry;
		@(posedge clk) disable iff (!rst_n)
		(burnTrigger && !running && !locked && status_reg != otpfw_pkg::VAL_READY) |=> running;
	endproperty
	a_retry: assert property (p_retry) else $error("retry trigger not taken");

	property p_idleburn;
		@(posedge clk) disable iff (!rst_n)
		!running |-> !testBurn_reg && !lockBurn_reg && dataBurn_reg == 8'h00;
	endproperty
	a_idleburn: assert property (p_idleburn) else $error("burn strobe outside a sequence");

	property p_datasubset;
		@(posedge clk) disable iff (!rst_n)
		(dataBurn_reg & ~wiper_code_reg) == 8'h00;
	endproperty
	a_datasubset: assert property (p_datasubset) else $error("data fuse burned for a zero bit");

	property p_lockstrobe;
		@(posedge clk) disable iff (!rst_n)
		lockBurn_reg |-> state_reg == otpfw_pkg::OTPFW_LOCK;
	endproperty
	a_lockstrobe: assert property (p_lockstrobe) else $error("lock fuse burned outside lock phase");

	property p_tickgap;
		@(posedge clk) disable iff (!rst_n)
		tick |-> running ##1 !tick;
	endproperty
	a_tickgap: assert property (p_tickgap) else $error("pacing pulse outside a sequence");

	property p_tapdecode;
		@(posedge clk) disable iff (!rst_n)
		tapSelect[wiper_code_reg] && $onehot(tapSelect);
	endproperty
	a_tapdecode: assert property (p_tapdecode) else $error("tap decode not one-hot");

	// Scenario coverage
	c_testfail: cover property (@(posedge clk) disable iff (!rst_n) status_reg == 2'h1);
	c_mismatch: cover property (@(posedge clk) disable iff (!rst_n) status_reg == 2'h2);
	c_locked: cover property (@(posedge clk) disable iff (!rst_n) status_reg == 2'h3);
	c_retry: cover property (@(posedge clk) disable iff (!rst_n) startSeq && status_reg == otpfw_pkg::VAL_MISMATCH);
	c_relatch: cover property (@(posedge clk) disable iff (!rst_n) !bootDone_reg && lockFuseSense);
endmodule : otpfw_core

`default_nettype wire

// [hdl/otpfw_pkg.sv]
// Package for the fuse-based one-time-programmable wiper setting block.
// Assumes a single 50 MHz clock and an asynchronous active-low reset.
`default_nettype none

package otpfw_pkg;
	// ==========================================================
	// Widths and codes
	localparam int CODE_W = 8;
	localparam logic [7:0] MIDSCALE_CODE = 8'h80;
	localparam int TAP_COUNT = 256;
	localparam logic [1:0] VAL_READY = 2'h0;
	localparam logic [1:0] VAL_TEST_FAIL = 2'h1;
	localparam logic [1:0] VAL_MISMATCH = 2'h2;
	localparam logic [1:0] VAL_LOCKED = 2'h3;
	// ==========================================================
	// Timing: internal programming clock derived from clk
	localparam int CLK_HZ = 50000000;
	localparam int PROG_CLK_HZ = 1000000;
	localparam int PROG_DIV = CLK_HZ / PROG_CLK_HZ;
	localparam logic [7:0] PROG_DIV_LAST = 8'(PROG_DIV - 1);
	localparam logic [2:0] DATA_FUSE_LAST = 3'h7;
	// ==========================================================
	// Sequencer states, Gray coded along the usual path
	typedef enum logic [2:0] {
		OTPFW_IDLE = 3'h0,
		OTPFW_TEST = 3'h1,
		OTPFW_DATA = 3'h3,
		OTPFW_CMP = 3'h2,
		OTPFW_LOCK = 3'h6
	} otpfw_state_t;
endpackage : otpfw_pkg

`default_nettype wire

// [hdl/otpfw_tick.sv]
// Enable divider that paces the fuse sequencer.
// Assumes the enable input is high only while a sequence runs.
`default_nettype none

module otpfw_tick (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic tick
);
	logic [7:0] cnt_reg;

	// ==========================================================
	// Counter restarts with every sequence, so the first pulse has a fixed delay
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_reg <= 8'h00;
		else if (!run || cnt_reg == otpfw_pkg::PROG_DIV_LAST)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end

	assign tick = run && (cnt_reg == otpfw_pkg::PROG_DIV_LAST);
endmodule : otpfw_tick

`default_nettype wire

// [testbench/otpfw_fuse_model.sv]
// Behavioural fuse array facing the wiper programmer.
// Assumes burn strobes are sampled on clk; fuses survive resets.
`default_nettype none

module otpfw_fuse_model (
	input wire logic clk,
	input wire logic breakTest,
	input wire logic [7:0] stuckMask,
	input wire logic testFuseBurn,
	input wire logic [7:0] dataFuseBurn,
	input wire logic lockFuseBurn,
	output logic testFuseSense,
	output logic [7:0] dataFuseSense,
	output logic lockFuseSense
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Fuse state
	// Blank fuses at start; no reset input, as fuses are nonvolatile
	logic testBlown = 1'b0;
	logic [7:0] dataBlown = 8'h00;
	logic lockBlown = 1'b0;
	// A blown fuse never heals; stuck bits mimic a weak data fuse
	always @(posedge clk)
	begin
		if (testFuseBurn && !breakTest)
			testBlown <= 1'b1;
		dataBlown <= dataBlown | (dataFuseBurn & ~stuckMask);
		if (lockFuseBurn)
			lockBlown <= 1'b1;
	end
	// Sense outputs show the fuse state directly
	assign testFuseSense = testBlown;
	assign dataFuseSense = dataBlown;
	assign lockFuseSense = lockBlown;
endmodule : otpfw_fuse_model

`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the fuse wiper programmer.
// Assumes the fuse model above and a 50 MHz clock.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, codeWrite, burnTrigger, breakTest;
	logic [7:0] codeData, stuckMask, dataFuseBurn, dataFuseSense, wiperCode, wiperToACode;
	logic testFuseSense, lockFuseSense, testFuseBurn, lockFuseBurn, validation_hi, validation_lo, busy;
	logic [255:0] tapSelect;
	int errors, comparisons, expCode, expStat, fused;
	// ==========================================================
	// Design and fuse array
	otpfw_core dut (.clk(clk), .rst_n(rst_n), .codeWrite(codeWrite), .codeData(codeData),
		.burnTrigger(burnTrigger), .testFuseSense(testFuseSense), .dataFuseSense(dataFuseSense),
		.lockFuseSense(lockFuseSense), .testFuseBurn(testFuseBurn), .dataFuseBurn(dataFuseBurn),
		.lockFuseBurn(lockFuseBurn), .wiperCode(wiperCode), .tapSelect(tapSelect),
		.wiperToACode(wiperToACode), .validation_hi(validation_hi), .validation_lo(validation_lo), .busy(busy));
	otpfw_fuse_model fuses (.clk(clk), .breakTest(breakTest), .stuckMask(stuckMask),
		.testFuseBurn(testFuseBurn), .dataFuseBurn(dataFuseBurn), .lockFuseBurn(lockFuseBurn),
		.testFuseSense(testFuseSense), .dataFuseSense(dataFuseSense), .lockFuseSense(lockFuseSense));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ==========================================================
	// Shared tasks
	// Inputs move 2 ns after the edge so no race with sampling
	task automatic step();
		@(posedge clk);
		#2;
	endtask : step
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// Model against design at every result
	task automatic compare_all(string name);
		check("code", wiperCode, 8'(expCode));
		check("toA", wiperToACode, ~8'(expCode));
		check("tap", {7'h00, tapSelect[expCode]}, 8'h01);
		check("taps", 8'($countones(tapSelect)), 8'h01);
		check("status", {6'h00, validation_hi, validation_lo}, 8'(expStat));
		$display("test %s done", name);
	endtask : compare_all
	task automatic reset_dut();
		rst_n = 1'b0;
		repeat (6) step();
		rst_n = 1'b1;
		step();
		step();
	endtask : reset_dut
	// Writes are refused once locked
	task automatic write_code(logic [7:0] v);
		codeWrite = 1'b1;
		codeData = v;
		step();
		codeWrite = 1'b0;
		if (expStat != 3) expCode = v;
		step();
	endtask : write_code
	// Trigger, poke writes and triggers mid-run, wait for the end
	task automatic burn();
		int n;
		int phase;
		int phases;
		logic [7:0] expBurn;
		burnTrigger = 1'b1;
		step();
		burnTrigger = 1'b0;
		phases = 0;
		check("busy", {7'h00, busy}, (expStat == 3) ? 8'h00 : 8'h01);
		// Strobes per pacing period: test, eight data bits LSB first, compare, lock
		for (n = 0; n < 1000 && busy === 1'b1; n++)
		begin
			phase = n / otpfw_pkg::PROG_DIV;
			expBurn = (phase >= 1 && phase <= 8) ? 8'(expCode & (1 << (phase - 1))) : 8'h00;
			check("databurn", dataFuseBurn, expBurn);
			expBurn = (phase == 0) ? 8'h02 : ((phase == 10) ? 8'h01 : 8'h00);
			check("ctlburn", {6'h00, testFuseBurn, lockFuseBurn}, expBurn);
			if (n == 100 || n == 101)
			begin
				codeWrite = (n == 100);
				burnTrigger = (n == 100);
				codeData = ~8'(expCode);
			end
			step();
		end
		if (busy !== 1'b0)
		begin
			check("timeout", {7'h00, busy}, 8'h00);
			complete_run();
		end
		if (expStat != 3)
		begin
			if (breakTest)
			begin
				expStat = 1;
				phases = 1;
			end
			else
			begin
				fused = fused | (expCode & ~int'(stuckMask));
				expStat = (fused == expCode) ? 3 : 2;
				phases = (expStat == 3) ? 11 : 10;
			end
		end
		check("phases", 8'(n / otpfw_pkg::PROG_DIV), 8'(phases));
		check("phaselen", 8'(n % otpfw_pkg::PROG_DIV), 8'h00);
		step();
	endtask : burn
	// ==========================================================
	// Main sequence
	initial
	begin
		{rst_n, codeWrite, burnTrigger, breakTest, codeData, stuckMask} = '0;
		errors = 0;
		comparisons = 0;
		fused = 0;
		expCode = 128;
		expStat = 0;
		void'($urandom(22));
		reset_dut();
		compare_all("preset");
		repeat (4) write_code(8'($urandom));
		compare_all("writes");
		breakTest = 1'b1;
		write_code(8'hA5);
		burn();
		compare_all("testfuse");
		breakTest = 1'b0;
		stuckMask = 8'h04;
		burn();
		compare_all("mismatch");
		stuckMask = 8'h00;
		burn();
		compare_all("retry");
		check("lock", {7'h00, lockFuseSense}, 8'h01);
		write_code(8'h3C);
		burn();
		compare_all("refused");
		reset_dut();
		expCode = fused;
		compare_all("relatch");
		complete_run();
	end
endmodule : tb_top

`default_nettype wire
